// File: tester_remote_io_status_interlock_tb.sv
// Purpose: self-checking bench of the remote i/o status block
// Assumes: debounce of 1000 cycles, ce held high
// Notes: apb results checked from a queue of notes
`timescale 1ns/1ps
module tester_remote_io_status_interlock_tb import trio_pkg::*; ;
    typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} trio_note_t;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic pready, pslverr, start_n, stop_n, external_io_enable_n, interlock_n;
    logic ready_n, test_n, hv_on_n, pass_n, upper_fail_n, lower_fail_n, hazard_lamp;
    logic withstand_mode_n, insulation_mode_n, withstand_fail_n, insulation_fail_n, hv_enable;
    logic [15:0] meas_volt;
    logic [8:0] pins;
    logic [31:0] fcmd [3] = '{32'h10, 32'h20, 32'h30};
    logic [8:0] fexp [3] = '{9'h1D1, 9'h1E2, 9'h1C2};
    int num_errors = 0, checked = 0, cycles = 0;
    trio_note_t notes[$];
    trio_note_t n;
    assign pins = {ready_n, test_n, pass_n, upper_fail_n, lower_fail_n, withstand_mode_n,
        insulation_mode_n, withstand_fail_n, insulation_fail_n};
    trio_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_n(start_n), .stop_n(stop_n),
        .external_io_enable_n(external_io_enable_n), .interlock_n(interlock_n),
        .meas_volt(meas_volt), .ready_n(ready_n), .test_n(test_n), .hv_on_n(hv_on_n),
        .pass_n(pass_n), .upper_fail_n(upper_fail_n), .lower_fail_n(lower_fail_n),
        .withstand_mode_n(withstand_mode_n), .insulation_mode_n(insulation_mode_n),
        .withstand_fail_n(withstand_fail_n), .insulation_fail_n(insulation_fail_n),
        .hazard_lamp(hazard_lamp), .hv_enable(hv_enable));
    trio_ctl_model ctl_u (.sys_clk(sys_clk), .hv_enable(hv_enable), .start_n(start_n),
        .stop_n(stop_n), .external_io_enable_n(external_io_enable_n),
        .interlock_n(interlock_n), .meas_volt(meas_volt));
    initial forever #5 sys_clk = ~sys_clk;
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task end_of_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // read: d is the expected word; write: only the error flag is noted
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic e);
        notes.push_back('{d, w ? 32'h0 : m, e});
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    always @(posedge sys_clk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected answer", 32'h0, 32'h1);
            end else begin
                n = notes.pop_front();
                chk("prdata", n.exp & n.mask, prdata & n.mask);
                chk("pslverr", {31'h0, n.err}, {31'h0, pslverr});
            end
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        v = $urandom(32'hCDF89338);
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(0, 8'h00, 32'h0, 32'h7F, 0);
        apb(0, 8'h10, 32'h0, 32'hFFFFFFFF, 1);
        apb(0, 8'h04, 32'h0, 32'hFFFFFFFF, 0);
        apb(1, 8'h00, 32'h1, 0, 0);
        apb(0, 8'h00, 32'h0, 32'h1, 0);
        repeat (4) begin
            v = $urandom;
            apb(1, 8'h08, v, 0, 0);
            apb(0, 8'h08, v, 32'hFFFF, 0);
        end
        chk("ready pins", 9'h0FF, pins);
        apb(1, 8'h00, 32'h2, 0, 0);
        ctl_u.drive(1, 1, 0, 1);
        repeat (1100) @(posedge sys_clk);
        ctl_u.drive(0, 1, 0, 1);
        for (int i = 0; i < 1500 && test_n !== 1'b0; i++) @(posedge sys_clk);
        chk("test pins", 9'h177, pins);
        ctl_u.drive(1, 1, 0, 1);
        apb(1, 8'h04, 32'h8, 0, 0);
        repeat (300) @(posedge sys_clk);
        chk("pass pins", 9'h1B3, pins & 9'h1F3);
        apb(1, 8'h04, 32'h4, 0, 0);
        for (int i = 0; i < 100 && ready_n !== 1'b0; i++) @(posedge sys_clk);
        chk("cleared pins", 9'h0FF, pins);
        for (int k = 0; k < 3; k++) begin
            apb(1, 8'h00, (k > 0) ? 32'h14 : 32'h4, 0, 0);
            apb(1, 8'h04, 32'h1, 0, 0);
            for (int i = 0; i < 100 && test_n !== 1'b0; i++) @(posedge sys_clk);
            apb(1, 8'h04, fcmd[k], 0, 0);
            repeat (300) @(posedge sys_clk);
            chk("fail pins", fexp[k], pins & 9'h1F3);
            apb(1, 8'h04, 32'h4, 0, 0);
            for (int i = 0; i < 100 && ready_n !== 1'b0; i++) @(posedge sys_clk);
        end
        apb(1, 8'h00, 32'h0, 0, 0);
        apb(1, 8'h04, 32'h1, 0, 0);
        for (int i = 0; i < 100 && test_n !== 1'b0; i++) @(posedge sys_clk);
        ctl_u.drive(1, 0, 0, 1);
        for (int i = 0; i < 1500 && ready_n !== 1'b0; i++) @(posedge sys_clk);
        chk("stop pins", 9'h0FF, pins);
        ctl_u.drive(1, 1, 0, 1);
        repeat (1100) @(posedge sys_clk);
        // comparison level reached: test pin released while still testing
        apb(1, 8'h08, 32'h64, 0, 0);
        apb(1, 8'h00, 32'h20, 0, 0);
        apb(1, 8'h04, 32'h1, 0, 0);
        repeat (20) @(posedge sys_clk);
        chk("comp test pins", 9'h1F7, pins);
        apb(1, 8'h04, 32'h2, 0, 0);
        repeat (100) @(posedge sys_clk);
        // auto test: first judgement waits for decay, then the other mode runs
        apb(1, 8'h00, 32'h8, 0, 0);
        apb(1, 8'h04, 32'h1, 0, 0);
        repeat (10) @(posedge sys_clk);
        apb(1, 8'h04, 32'h8, 0, 0);
        repeat (3) @(posedge sys_clk);
        chk("decay test_n", 32'h0, {31'h0, test_n});
        repeat (60) @(posedge sys_clk);
        chk("second test pins", 9'h17B, pins);
        apb(1, 8'h04, 32'h2, 0, 0);
        repeat (100) @(posedge sys_clk);
        apb(1, 8'h00, 32'h40, 0, 0);
        repeat (3) @(posedge sys_clk);
        chk("setting pins", 9'h1FF, pins);
        apb(1, 8'h00, 32'h0, 0, 0);
        ctl_u.drive(1, 1, 0, 0);
        repeat (1100) @(posedge sys_clk);
        apb(1, 8'h00, 32'h1, 0, 0);
        apb(0, 8'h00, 32'h1, 32'h1, 0);
        ctl_u.drive(1, 1, 1, 1);
        repeat (1100) @(posedge sys_clk);
        apb(0, 8'h0C, 32'h440, 32'h47F, 0);
        chk("hv cut", 32'h0, {31'h0, hv_enable});
        apb(1, 8'h04, 32'h1, 0, 0);
        repeat (3) @(posedge sys_clk);
        apb(0, 8'h0C, 32'h440, 32'h47F, 0);
        ctl_u.drive(1, 1, 1, 0);
        for (int i = 0; i < 1500 && ready_n !== 1'b0; i++) @(posedge sys_clk);
        chk("unlock ready", 32'h0, {31'h0, ready_n});
        end_of_test();
    end
endmodule : tester_remote_io_status_interlock_tb

// File: trio_ctl_model.sv
// Purpose: external controller pins and generator voltage
// Assumes: pins change only just after a clock edge
// Notes: voltage ramps with hv_enable, decays without it
`timescale 1ns/1ps
module trio_ctl_model (
    input wire logic sys_clk,
    input wire logic hv_enable,
    output logic start_n,
    output logic stop_n,
    output logic external_io_enable_n,
    output logic interlock_n,
    output logic [15:0] meas_volt
);
    // all pins idle until told otherwise, so power-on levels are never relied on
    initial begin
        start_n = 1'b1;
        stop_n = 1'b1;
        external_io_enable_n = 1'b1;
        interlock_n = 1'b1;
    end
    task drive(input logic s, input logic p, input logic e, input logic i);
        @(posedge sys_clk);
        start_n <= s;
        stop_n <= p;
        external_io_enable_n <= e;
        interlock_n <= i;
    endtask : drive
    initial meas_volt = 16'h0000;
    always @(posedge sys_clk) begin
        if (hv_enable) begin
            meas_volt <= (meas_volt < 16'h01F4) ? meas_volt + 16'h0032 : meas_volt;
        end else begin
            meas_volt <= (meas_volt > 16'h0014) ? meas_volt - 16'h0014 : 16'h0000;
        end
    end
endmodule : trio_ctl_model

// File: trio_map.svh
// Purpose: offsets, fields, reset values and timing counts
// Assumes: 100 MHz sys_clk, APB byte addresses
// Notes: definitions only
`ifndef TRIO_MAP_SVH
`define TRIO_MAP_SVH
`define TRIO_CLK_MHZ 100
`define TRIO_OFS_CTRL 8'h00
`define TRIO_OFS_CMD 8'h04
`define TRIO_OFS_COMP 8'h08
`define TRIO_OFS_STAT 8'h0C
`define TRIO_CTRL_ILOCK 0
`define TRIO_CTRL_PHOLD 1
`define TRIO_CTRL_FHOLD 2
`define TRIO_CTRL_AUTO 3
`define TRIO_CTRL_INSUL 4
`define TRIO_CTRL_COMP 5
`define TRIO_CTRL_SETUP 6
`define TRIO_CTRL_RST 7'h00
`define TRIO_CMD_START 0
`define TRIO_CMD_STOP 1
`define TRIO_CMD_CLEAR 2
`define TRIO_CMD_PASS 3
`define TRIO_CMD_UPPER 4
`define TRIO_CMD_LOWER 5
`define TRIO_WV_SAFE_V 16'h001E
`define TRIO_IR_SAFE_V 16'h0032
`define TRIO_DEB_US 10
`define TRIO_DEB_CYC (`TRIO_DEB_US * `TRIO_CLK_MHZ)
`define TRIO_RESULT_MS 500
`define TRIO_RESULT_CYC (`TRIO_RESULT_MS * 1000 * `TRIO_CLK_MHZ)
`endif

// File: trio_monitor.sv
// Purpose: concurrent checks on the remote i/o status pins
// Assumes: single sys_clk domain, rstn synchronous active low
// Notes: bound to trio_top below
`timescale 1ns/1ps
module trio_monitor (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ready_n,
    input wire logic test_n,
    input wire logic pass_n,
    input wire logic upper_fail_n,
    input wire logic lower_fail_n,
    input wire logic withstand_mode_n,
    input wire logic insulation_mode_n,
    input wire logic withstand_fail_n,
    input wire logic insulation_fail_n,
    input wire logic hazard_lamp,
    input wire logic hv_on_n,
    input wire logic hv_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    apb_answer_a: assert property (setup_s |=> answer_s)
        else $error("apb answer missing");
    err_pulse_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    ready_idle_a: assert property (!ready_n |-> test_n && pass_n)
        else $error("ready with test or pass");
    hv_lamp_a: assert property (hazard_lamp ^ hv_on_n)
        else $error("hv pin off lamp");
    pass_clean_a: assert property (!pass_n |-> upper_fail_n && lower_fail_n)
        else $error("pass with fail");
    fail_kind_a: assert property ((!upper_fail_n || !lower_fail_n)
        |-> withstand_fail_n != insulation_fail_n)
        else $error("fail kind wrong");
    mode_excl_a: assert property (withstand_mode_n || insulation_mode_n)
        else $error("both modes low");
    hv_gate_a: assert property (hv_enable |-> ready_n && pass_n && upper_fail_n)
        else $error("hv on outside test");
endmodule : trio_monitor

bind trio_top trio_monitor mon_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .ready_n(ready_n),
    .test_n(test_n), .pass_n(pass_n), .upper_fail_n(upper_fail_n),
    .lower_fail_n(lower_fail_n), .withstand_mode_n(withstand_mode_n),
    .insulation_mode_n(insulation_mode_n), .withstand_fail_n(withstand_fail_n),
    .insulation_fail_n(insulation_fail_n), .hazard_lamp(hazard_lamp),
    .hv_on_n(hv_on_n), .hv_enable(hv_enable));

// File: trio_pkg.sv
// Purpose: types of the remote i/o status block
// Assumes: nothing
// Notes: one-hot sequence states
package trio_pkg;
    typedef enum logic [6:0] {
        TRIO_SETUP = 7'h01,
        TRIO_READY = 7'h02,
        TRIO_TEST = 7'h04,
        TRIO_DECAY = 7'h08,
        TRIO_PASS = 7'h10,
        TRIO_FAIL = 7'h20,
        TRIO_LOCK = 7'h40
    } trio_state_t;
endpackage : trio_pkg

// File: trio_top.sv
// Purpose: status outputs and interlock of the isolated remote i/o port
// Assumes: firmware posts judgements over APB; meas_volt in volts, same clock
// Notes: all status pins active low, registered
//
// Overview of operation
// R01: status outputs are low only while their condition holds, else high.
// R02: controller holds the enable line low for remote inputs to act.
// R03: start low while ready low begins a test.
// R04: test start releases ready, drives test and high voltage low.
// R05: with comparison set, test low only while the indicator flashes.
// R06: high voltage output follows hazard lamp until voltage under 30 V or 50 V.
// R07: pass releases test and drives pass low.
// R08: pass hold keeps pass low until hold cleared.
// R09: clearing hold or auto return releases pass and drives ready low.
// R10: upper failure drives upper fail low, lower failure lower fail low.
// R11: fail hold keeps fail outputs low until hold cleared.
// R12: withstand failure drives withstand fail, insulation failure insulation fail.
// R13: comparison never reached drives upper and lower fail together.
// R14: stop termination gives no judgement; result outputs stay high.
// R15: setting, save/load or option screens release every status output.
// R16: auto test waits for decay; test output stays low throughout.
// R17: engaged interlock cuts high voltage and ignores all keys.
// R18: interlock input works whatever the enable line does.
// R19: interlock option resets to 0; at 0 the interlock is inactive.
// R20: option may become 1 only while the interlock input is low.
// R21: option set and input high engages; input low releases to ready.
// R22: controller must not trust status levels right after power-on.
// R23: mode outputs low while a withstand or insulation test runs.
// R24: start and stop inputs act like the front panel keys.
// R25: stop input acts whatever the enable line does.
// R26: inputs are synchronised and debounced; one start edge starts one test.
`timescale 1ns/1ps
`include "trio_map.svh"

module trio_top
    import trio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_n,
    input wire logic stop_n,
    input wire logic external_io_enable_n,
    input wire logic interlock_n,
    input wire logic [15:0] meas_volt,
    output logic ready_n,
    output logic test_n,
    output logic hv_on_n,
    output logic pass_n,
    output logic upper_fail_n,
    output logic lower_fail_n,
    output logic withstand_mode_n,
    output logic insulation_mode_n,
    output logic withstand_fail_n,
    output logic insulation_fail_n,
    output logic hazard_lamp,
    output logic hv_enable
);
    localparam int NIN = 4;
    localparam logic [15:0] DEB_CYC = 16'(`TRIO_DEB_CYC);
    localparam logic [31:0] RESULT_CYC = 32'(`TRIO_RESULT_CYC);

    // pin inputs: 0 start, 1 stop, 2 enable, 3 interlock (0 to 2 low active; interlock engages when high)
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] deb_lvl;
    assign pin_raw = {interlock_n, external_io_enable_n, stop_n, start_n};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            logic s1;
            logic s2;
            logic [15:0] cnt;
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                end else if (ce) begin
                    s1 <= pin_raw[gi];
                    s2 <= s1;
                end
            end
            // a new contact level must hold for a full window before it counts
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    deb_lvl[gi] <= 1'b1;
                    cnt <= 16'h0000;
                end else if (ce) begin
                    if (s2 == deb_lvl[gi]) begin
                        cnt <= 16'h0000;
                    end else if (cnt == DEB_CYC - 16'h0001) begin
                        deb_lvl[gi] <= s2; // see R26
                        cnt <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    logic [NIN-1:0] deb_q;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            deb_q <= {NIN{1'b1}};
        end else if (ce) begin
            deb_q <= deb_lvl;
        end
    end

    logic ext_en;
    logic ext_start;
    logic ext_stop;
    logic ext_en_chg;
    logic il_open;
    assign ext_en = ~deb_lvl[2]; // see R02
    assign ext_start = ext_en & deb_q[0] & ~deb_lvl[0]; // see R24 R26
    assign ext_stop = ~deb_lvl[1]; // see R25
    assign ext_en_chg = deb_q[2] ^ deb_lvl[2];
    assign il_open = deb_lvl[3];

    // register file
    logic [6:0] ctrl;
    logic [15:0] comp_volt;
    logic [5:0] cmd;
    logic wr_acc;
    logic rd_acc;
    assign wr_acc = psel & penable & pready & pwrite;
    assign rd_acc = psel & ~penable;

    logic lock_on;
    assign lock_on = ctrl[`TRIO_CTRL_ILOCK] & il_open; // see R19 R21 R18

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl <= `TRIO_CTRL_RST; // see R19
            comp_volt <= 16'h0000;
        end else if (ce && wr_acc) begin
            if (paddr == `TRIO_OFS_CTRL) begin
                ctrl <= pwdata[6:0];
                // option may rise only with the loop closed
                if (il_open && !ctrl[`TRIO_CTRL_ILOCK]) begin
                    ctrl[`TRIO_CTRL_ILOCK] <= 1'b0; // see R20
                end
            end else if (paddr == `TRIO_OFS_COMP) begin
                comp_volt <= pwdata[15:0];
            end
        end
    end

    // command strobes; keys are dropped while locked
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cmd <= 6'h00;
        end else if (ce) begin
            if (wr_acc && paddr == `TRIO_OFS_CMD) begin
                cmd <= pwdata[5:0];
            end else begin
                cmd <= 6'h00;
            end
        end
    end

    trio_state_t state;
    trio_state_t next_state;
    logic insul;
    logic next_insul;
    logic first_done;
    logic next_first_done;
    logic [1:0] fail_kind;
    logic [1:0] next_fail_kind;
    logic [31:0] res_cnt;

    logic safe_v;
    logic comp_hit;
    logic any_start;
    logic any_stop;
    logic judge;
    logic fail_j;
    logic res_hold;
    assign safe_v = insul ? (meas_volt < `TRIO_IR_SAFE_V) : (meas_volt < `TRIO_WV_SAFE_V);
    assign comp_hit = meas_volt >= comp_volt;
    assign any_start = ext_start | cmd[`TRIO_CMD_START];
    assign any_stop = ext_stop | cmd[`TRIO_CMD_STOP];
    assign fail_j = cmd[`TRIO_CMD_UPPER] | cmd[`TRIO_CMD_LOWER];
    assign judge = cmd[`TRIO_CMD_PASS] | fail_j;
    assign res_hold = (state == TRIO_PASS) ? ctrl[`TRIO_CTRL_PHOLD] : ctrl[`TRIO_CTRL_FHOLD];

    always_comb begin
        next_state = state;
        next_insul = insul;
        next_first_done = first_done;
        next_fail_kind = fail_kind;
        unique case (state)
            TRIO_SETUP: begin
                if (!ctrl[`TRIO_CTRL_SETUP]) begin
                    next_state = TRIO_READY;
                end
            end
            TRIO_READY: begin
                if (any_start) begin // see R03
                    next_state = TRIO_TEST;
                    next_insul = ctrl[`TRIO_CTRL_INSUL];
                    next_first_done = 1'b0;
                end
            end
            TRIO_TEST: begin
                if (any_stop || ext_en_chg) begin
                    next_state = TRIO_READY; // see R14
                end else if (fail_j) begin
                    next_state = TRIO_FAIL;
                    // both bits set when comparison never reached
                    next_fail_kind = {cmd[`TRIO_CMD_UPPER], cmd[`TRIO_CMD_LOWER]}; // see R13
                end else if (judge) begin
                    if (ctrl[`TRIO_CTRL_AUTO] && !first_done) begin
                        next_state = TRIO_DECAY; // see R16
                    end else begin
                        next_state = TRIO_PASS;
                    end
                end
            end
            TRIO_DECAY: begin
                if (any_stop) begin
                    next_state = TRIO_READY;
                end else if (safe_v) begin
                    next_state = TRIO_TEST; // see R16
                    next_insul = ~insul;
                    next_first_done = 1'b1;
                end
            end
            TRIO_PASS, TRIO_FAIL: begin
                if (any_stop || cmd[`TRIO_CMD_CLEAR]) begin
                    next_state = TRIO_READY; // see R09
                end else if (!res_hold && res_cnt == RESULT_CYC) begin
                    next_state = TRIO_READY; // see R08 R11
                end
            end
            TRIO_LOCK: begin
                next_state = TRIO_READY; // see R21
            end
        endcase
        if (ctrl[`TRIO_CTRL_SETUP]) begin
            next_state = TRIO_SETUP;
        end
        if (lock_on) begin
            next_state = TRIO_LOCK; // see R17
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= TRIO_SETUP;
            insul <= 1'b0;
            first_done <= 1'b0;
            fail_kind <= 2'b00;
        end else if (ce) begin
            state <= next_state;
            insul <= next_insul;
            first_done <= next_first_done;
            fail_kind <= next_fail_kind;
        end
    end

    // result display time before automatic return
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            res_cnt <= 32'h00000000;
        end else if (ce) begin
            if (state != next_state || res_hold) begin
                res_cnt <= 32'h00000000;
            end else if (res_cnt != RESULT_CYC) begin
                res_cnt <= res_cnt + 32'h00000001;
            end
        end
    end

    // pin drive; lamp keeps burning while the output is still charged, except in setup
    logic in_test;
    logic lamp;
    logic in_res;
    assign in_test = (state == TRIO_TEST) || (state == TRIO_DECAY);
    assign lamp = (state == TRIO_TEST) || (state != TRIO_SETUP && !safe_v);
    assign in_res = (state == TRIO_PASS) || (state == TRIO_FAIL);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ready_n <= 1'b1;
            test_n <= 1'b1;
            hv_on_n <= 1'b1;
            pass_n <= 1'b1;
            upper_fail_n <= 1'b1;
            lower_fail_n <= 1'b1;
            withstand_mode_n <= 1'b1;
            insulation_mode_n <= 1'b1;
            withstand_fail_n <= 1'b1;
            insulation_fail_n <= 1'b1;
            hazard_lamp <= 1'b0;
            hv_enable <= 1'b0;
        end else if (ce) begin
            ready_n <= ~(state == TRIO_READY); // see R01 R09 R15
            // flashing lasts until the comparison level is reached
            test_n <= ~(in_test && !(ctrl[`TRIO_CTRL_COMP] && state == TRIO_TEST
                && comp_hit)); // see R04 R05 R07 R16
            hv_on_n <= ~lamp; // see R06 R04
            hazard_lamp <= lamp;
            hv_enable <= (state == TRIO_TEST) && !lock_on; // see R17
            pass_n <= ~(state == TRIO_PASS); // see R07 R14
            upper_fail_n <= ~(state == TRIO_FAIL && fail_kind[1]); // see R10 R11
            lower_fail_n <= ~(state == TRIO_FAIL && fail_kind[0]); // see R10 R13
            withstand_mode_n <= ~(in_test && !insul); // see R23
            insulation_mode_n <= ~(in_test && insul); // see R23
            withstand_fail_n <= ~(state == TRIO_FAIL && !insul); // see R12
            insulation_fail_n <= ~(state == TRIO_FAIL && insul); // see R12
        end
    end

    // apb: no wait states, pready pulses for one cycle
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= rd_acc;
            pslverr <= rd_acc && paddr != `TRIO_OFS_CTRL && paddr != `TRIO_OFS_CMD
                && paddr != `TRIO_OFS_COMP && paddr != `TRIO_OFS_STAT;
            prdata <= 32'h00000000;
            if (rd_acc && !pwrite) begin
                unique case (paddr)
                    `TRIO_OFS_CTRL: prdata <= {25'h0000000, ctrl};
                    `TRIO_OFS_COMP: prdata <= {16'h0000, comp_volt};
                    `TRIO_OFS_STAT: prdata <= {16'h0000, deb_lvl, 1'b0, lock_on,
                        fail_kind, insul, state};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule : trio_top
